/* File: verilog/wdt_core.sv */
// watchdog timing core: control register, counter, halt handling, reset request
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wdt_core (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // cpu events and straps
  input wire logic halt_req,
  input wire logic osc_irq,
  input wire logic ext_irq,
  input wire logic halt_reset_option,
  // results
  output logic wdg_reset,
  output logic halted
);
  wdt_pkg::wdt_ctrl_s ctrl;
  logic activation_bit;
  logic [6:0] wdg_count;
  wdt_pkg::wdt_clk_s clk_ctrl;
  wdt_pkg::wdt_mode_e mode;
  logic tick;
  logic wr_wdg;
  logic wr_clk;
  logic frozen;
  logic roll;
  logic soft_reset;
  logic halt_reset;
  logic next_halted;

  assign wr_wdg = wr && (addr == wdt_pkg::ADDR_WDG_CTRL);
  assign wr_clk = wr && (addr == wdt_pkg::ADDR_CLK_CTRL);
  // plain halt lets one more decrement through before stopping
  assign frozen = (mode == wdt_pkg::WDT_AHALT);

  wdt_prescaler u_presc (
    .mclk(mclk),
    .resetn(resetn),
    .timebase_select(clk_ctrl.timebase_select),
    .tick(tick)
  );

  // rollover of the top bit
  // a stopped plain halt must not reset, so the roll follows the decrement enable
  assign roll = ctrl.activation_bit && tick && !frozen && !halted && !wr_wdg
    && (ctrl.count == wdt_pkg::CNT_ROLL_FROM);
  // writing top bit low with activation set forces a reset
  assign soft_reset = wr_wdg && (ctrl.activation_bit || wdata[7]) && !wdata[6];
  assign halt_reset = halt_req && !clk_ctrl.rtc_interrupt_enable && halt_reset_option
    && ctrl.activation_bit && (mode == wdt_pkg::WDT_RUN);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      clk_ctrl <= wdt_pkg::CLK_CTRL_RESET;
    else if (wr_clk)
      clk_ctrl <= wdata[2:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      activation_bit <= wdt_pkg::WDG_CTRL_RESET[7];
    else if (wr_wdg)
      activation_bit <= activation_bit | wdata[7];
  end

  // slow and wait do not reach this logic, so counting goes on
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      wdg_count <= wdt_pkg::WDG_CTRL_RESET[6:0];
    else if (wr_wdg)
      wdg_count <= wdata[6:0];
    else if (tick && !frozen && (mode != wdt_pkg::WDT_HALT || !halted))
      wdg_count <= wdg_count - 7'h01;
  end

  // one driver per field; the struct carries them to reads, checks and the reset request logic
  assign ctrl = {activation_bit, wdg_count};

  // active halt freezes, interrupts resume at once
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      mode <= wdt_pkg::WDT_RUN;
    else
    begin
      case (mode)
        wdt_pkg::WDT_RUN:
        begin
          if (halt_req && clk_ctrl.rtc_interrupt_enable)
            mode <= wdt_pkg::WDT_AHALT;
          else if (halt_req && !halt_reset)
            mode <= wdt_pkg::WDT_HALT;
        end
        wdt_pkg::WDT_AHALT:
        begin
          if (osc_irq || ext_irq)
            mode <= wdt_pkg::WDT_RUN;
        end
        wdt_pkg::WDT_HALT:
        begin
          if (ext_irq)
            mode <= wdt_pkg::WDT_RUN;
        end
        default: mode <= wdt_pkg::WDT_RUN;
      endcase
    end
  end

  // plain halt: stopped once the single decrement has happened
  always_comb
  begin
    next_halted = halted;
    if (mode != wdt_pkg::WDT_HALT || ext_irq)
      next_halted = 1'b0;
    else if (tick)
      next_halted = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      halted <= 1'b0;
    else
      halted <= next_halted;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      wdg_reset <= 1'b0;
    else
      wdg_reset <= roll || soft_reset || halt_reset;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (rd && addr == wdt_pkg::ADDR_WDG_CTRL)
      rdata <= ctrl;
    else if (rd && addr == wdt_pkg::ADDR_CLK_CTRL)
      rdata <= {4'h0, frozen || halted, clk_ctrl};
    else
      rdata <= 8'h00;
  end

  // helper: cycles since the last tick, and the timebase its step was cut with
  logic [14:0] gap;
  logic [1:0] tb_d;
  logic [1:0] step_tb;
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      gap <= 15'h0000;
    else if (tick)
      gap <= 15'h0001;
    else
      gap <= gap + 15'h0001;
  end

  // the prescaler picks a step length one edge before its tick is seen here
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      tb_d <= wdt_pkg::TB_2MS;
      step_tb <= wdt_pkg::TB_2MS;
    end
    else
    begin
      tb_d <= clk_ctrl.timebase_select;
      if (tick)
        step_tb <= tb_d;
    end
  end

  sequence seq_roll_cause;
    ctrl.activation_bit && tick && !frozen && !halted && !wr_wdg
    && ctrl.count == wdt_pkg::CNT_ROLL_FROM;
  endsequence

  sequence seq_active_halt_entry;
    (mode == wdt_pkg::WDT_RUN) && halt_req && clk_ctrl.rtc_interrupt_enable;
  endsequence

  chk_roll_resets: assert property (@(posedge mclk) disable iff (!resetn)
    seq_roll_cause |=> wdg_reset && ctrl.count == 7'h3F)
    else $error("rollover did not raise reset");

  chk_inactive_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    !ctrl.activation_bit && !(wr_wdg && wdata[7]) |=> !wdg_reset)
    else $error("reset raised while watchdog inactive");

  chk_act_sticky: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl.activation_bit |=> ctrl.activation_bit)
    else $error("activation bit cleared without reset");

  chk_refresh_load: assert property (@(posedge mclk) disable iff (!resetn)
    wr_wdg |=> ctrl.count == $past(wdata[6:0]))
    else $error("refresh did not load count");

  chk_decrement: assert property (@(posedge mclk) disable iff (!resetn)
    tick && mode == wdt_pkg::WDT_RUN && !wr_wdg |=> ctrl.count == $past(ctrl.count) - 7'h01)
    else $error("counter did not decrement on tick");

  chk_ahalt_freeze: assert property (@(posedge mclk) disable iff (!resetn)
    seq_active_halt_entry ##1 (!wr_wdg && !osc_irq && !ext_irq) [*2] |=> $stable(ctrl.count))
    else $error("counter moved in active halt");

  chk_ahalt_resume: assert property (@(posedge mclk) disable iff (!resetn)
    mode == wdt_pkg::WDT_AHALT && (osc_irq || ext_irq) |=> mode == wdt_pkg::WDT_RUN)
    else $error("active halt did not resume at once");

  chk_halt_reset: assert property (@(posedge mclk) disable iff (!resetn)
    mode == wdt_pkg::WDT_RUN && halt_req && !clk_ctrl.rtc_interrupt_enable
    && halt_reset_option && ctrl.activation_bit |=> wdg_reset ##1 mode == wdt_pkg::WDT_RUN)
    else $error("halt with option did not reset");

  chk_tick_period: assert property (@(posedge mclk) disable iff (!resetn)
    tick && $past(tick, 1) == 1'b0 && gap != 15'h0001 |->
    (gap == wdt_pkg::LONG_STEP || gap == wdt_pkg::wdt_short_step(step_tb)))
    else $error("tick spacing off");

  chk_read_ctrl: assert property (@(posedge mclk) disable iff (!resetn)
    rd && addr == wdt_pkg::ADDR_WDG_CTRL && !wr |=> rdata == $past(ctrl))
    else $error("control read wrong");
endmodule : wdt_core
`default_nettype wire

/* File: verilog/wdt_pkg.sv */
// shared constants, types and timing functions of the watchdog timing core
package wdt_pkg;
  localparam logic [7:0] ADDR_WDG_CTRL = 8'h2A;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h2B;
  localparam logic [7:0] WDG_CTRL_RESET = 8'h7F;
  localparam logic [2:0] CLK_CTRL_RESET = 3'h0;
  localparam logic [6:0] CNT_ROLL_FROM = 7'h40;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PERIOD_NS = 100;
  localparam int OSC_PER_CLK = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [14:0] LONG_STEP = 15'h4000;
  localparam logic [14:0] SHORT_UNIT = 15'h0040;
  localparam logic [14:0] SHORT_BASE = 15'h00C0;
  localparam logic [5:0] ACC_STEP = 6'h04;
  localparam logic [1:0] TB_2MS = 2'h0;
  localparam logic [1:0] TB_4MS = 2'h1;
  localparam logic [1:0] TB_10MS = 2'h2;
  localparam logic [1:0] TB_25MS = 2'h3;

  typedef struct packed {
    logic activation_bit;
    logic [6:0] count;
  } wdt_ctrl_s;

  typedef struct packed {
    logic rtc_interrupt_enable;
    logic [1:0] timebase_select;
  } wdt_clk_s;

  typedef enum logic [1:0] {
    WDT_RUN = 2'b00,
    WDT_AHALT = 2'b01,
    WDT_HALT = 2'b10
  } wdt_mode_e;

  function automatic logic [5:0] wdt_divider(input logic [1:0] tb);
    case (tb)
      TB_2MS: wdt_divider = 6'h04;
      TB_4MS: wdt_divider = 6'h08;
      TB_10MS: wdt_divider = 6'h14;
      default: wdt_divider = 6'h31;
    endcase
  endfunction : wdt_divider

  function automatic logic [5:0] wdt_offset(input logic [1:0] tb);
    case (tb)
      TB_2MS: wdt_offset = 6'h3B;
      TB_4MS: wdt_offset = 6'h35;
      TB_10MS: wdt_offset = 6'h23;
      default: wdt_offset = 6'h36;
    endcase
  endfunction : wdt_offset

  // replaced step length, (192 + offset) * 64 oscillator periods
  function automatic logic [14:0] wdt_short_step(input logic [1:0] tb);
    logic [14:0] sum;
    sum = SHORT_BASE + {9'h000, wdt_offset(tb)};
    wdt_short_step = 15'(sum * SHORT_UNIT);
  endfunction : wdt_short_step
endpackage : wdt_pkg

/* File: verilog/wdt_prescaler.sv */
// free-running prescaler shared with the rtc timebase, makes the decrement tick
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // timebase
  input wire logic [1:0] timebase_select,
  // decrement tick
  output logic tick
);
  logic [14:0] remain;
  logic [5:0] acc;
  logic [6:0] next_acc;
  logic next_short;

  always_comb
  begin
    next_acc = {1'b0, acc} + {1'b0, wdt_pkg::ACC_STEP};
    next_short = (next_acc >= {1'b0, wdt_pkg::wdt_divider(timebase_select)});
  end

  // one step in divider/4 is shortened
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      remain <= wdt_pkg::LONG_STEP - 15'h0001;
      acc <= 6'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (remain == 15'h0000);
      if (remain == 15'h0000)
      begin
        if (next_short)
        begin
          acc <= 6'(next_acc - {1'b0, wdt_pkg::wdt_divider(timebase_select)});
          remain <= wdt_pkg::wdt_short_step(timebase_select) - 15'h0001;
        end
        else
        begin
          acc <= next_acc[5:0];
          remain <= wdt_pkg::LONG_STEP - 15'h0001;
        end
      end
      else
      begin
        remain <= remain - 15'h0001;
      end
    end
  end
endmodule : wdt_prescaler
`default_nettype wire

/* File: verification/wdt_core_bench.sv */
// self-checking bench of the watchdog timing core
`timescale 1ns/1ps
`default_nettype none
module wdt_core_bench;
  logic mclk;
  logic resetn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic halt_req;
  logic osc_irq;
  logic ext_irq;
  logic halt_reset_option;
  logic wdg_reset;
  logic halted;
  logic got_rst;
  int n_fail;
  int n_checks;

  wdt_core wdt_core_inst (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .halt_req(halt_req), .osc_irq(osc_irq), .ext_irq(ext_irq),
    .halt_reset_option(halt_reset_option), .wdg_reset(wdg_reset), .halted(halted)
  );

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_in(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask : chk_in

  // one-cycle write; got_rst holds wdg_reset of the cycle after it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1 got_rst = wdg_reset;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask : rd_chk

  // 0 halt, 1 oscillator irq, 2 external irq
  task automatic pulse(input int k);
    @(posedge mclk);
    halt_req <= (k == 0);
    osc_irq <= (k == 1);
    ext_irq <= (k == 2);
    @(posedge mclk);
    {halt_req, osc_irq, ext_irq} <= 3'h0;
    #1 got_rst = wdg_reset;
  endtask : pulse

  // refresh with count cnt and time the reset request; slack covers registering
  task automatic measure(input logic [5:0] cnt, input int lo, input int hi);
    int n;
    wr_reg(wdt_pkg::ADDR_WDG_CTRL, {2'h3, cnt});
    n = 0;
    while (wdg_reset !== 1'b1 && n < hi + 10)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk_in(n, lo - 3, hi + 3);
  endtask : measure

  initial
  begin
    #(100 * 100000);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    n_fail = 0;
    n_checks = 0;
    {resetn, wr, rd, halt_req, osc_irq, ext_irq} = 6'h00;
    addr = 8'h00;
    wdata = 8'h00;
    halt_reset_option = 1'b1;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(wdt_pkg::ADDR_WDG_CTRL, 8'h7F); // off after reset
    rd_chk(wdt_pkg::ADDR_CLK_CTRL, 8'h00); // timebase after reset
    wr_reg(8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00);
    wr_reg(wdt_pkg::ADDR_WDG_CTRL, 8'h3F);
    chk8({7'h0, got_rst}, 8'h00); // inactive never resets
    rd_chk(wdt_pkg::ADDR_WDG_CTRL, 8'h3F); // count stored
    pulse(0);
    chk8({7'h0, got_rst}, 8'h00); // needs active watchdog
    pulse(2);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(wdt_pkg::ADDR_CLK_CTRL, 8'(i));
      rd_chk(wdt_pkg::ADDR_CLK_CTRL, 8'(i)); // timebase codes
    end
    wr_reg(wdt_pkg::ADDR_CLK_CTRL, 8'h00);
    // timebase 2ms: offset 59, step 251*64
    measure(6'h00, 11968, 16384); // count zero
    measure(6'h01, 28032, 32448); // shortened step
    wr_reg(wdt_pkg::ADDR_WDG_CTRL, 8'h7F);
    rd_chk(wdt_pkg::ADDR_WDG_CTRL, 8'hFF); // stays active
    wr_reg(wdt_pkg::ADDR_WDG_CTRL, 8'h80);
    chk8({7'h0, got_rst}, 8'h01); // cleared top bit resets
    wr_reg(wdt_pkg::ADDR_WDG_CTRL, 8'hFF);
    wr_reg(wdt_pkg::ADDR_CLK_CTRL, 8'h04);
    for (int k = 1; k < 3; k++)
    begin
      pulse(0);
      chk8({7'h0, got_rst}, 8'h00); // no reset on active halt
      rd_chk(wdt_pkg::ADDR_CLK_CTRL, 8'h0C); // counter frozen
      pulse(k);
      rd_chk(wdt_pkg::ADDR_CLK_CTRL, 8'h04); // wakes at once
    end
    wr_reg(wdt_pkg::ADDR_CLK_CTRL, 8'h00);
    pulse(0);
    chk8({7'h0, got_rst}, 8'h01); // halt resets
    // new timebase only counts from the next step boundary
    wr_reg(wdt_pkg::ADDR_CLK_CTRL, 8'h03);
    wr_reg(wdt_pkg::ADDR_WDG_CTRL, 8'hFF);
    // plain halt rides out one tick: one decrement, then stopped
    @(posedge mclk);
    halt_reset_option <= 1'b0;
    pulse(0);
    chk8({7'h0, got_rst}, 8'h00); // option off gives no reset
    repeat (16400) @(posedge mclk);
    #1 chk8({7'h0, halted}, 8'h01); // stopped after one tick
    rd_chk(wdt_pkg::ADDR_WDG_CTRL, 8'hFE); // one decrement only
    rd_chk(wdt_pkg::ADDR_CLK_CTRL, 8'h0B); // stop shows in status
    pulse(2);
    chk8({7'h0, halted}, 8'h00); // external irq wakes
    measure(6'h00, 11648, 16384); // offset 54
    report_and_stop();
  end
endmodule : wdt_core_bench
`default_nettype wire
